/* rtl/csfr_alu.sv */
// csfr_alu: datapath computing result and flags for one operation
// assumes: purely combinational, operands stable within the cycle
`timescale 1ns/10ps
module csfr_alu
  import csfr_pkg::*;
(
  input csfr_alu_req_s req,
  output csfr_alu_res_s res
);

  wire [8:0] add_sum;
  wire [4:0] add_nib;
  wire [8:0] sub_sum;
  wire [4:0] sub_nib;
  wire [7:0] neg_b;
  logic [7:0] logic_out;

  ////////////////////////////////////////////////////////////////////////
  // add carry out
  assign add_sum = {1'b0, req.a} + {1'b0, req.b};
  assign add_nib = {1'b0, req.a[3:0]} + {1'b0, req.b[3:0]};
  assign neg_b = 8'(~req.b + 8'h01);
  // b == 0 gives carry 1 (no borrow) via the +1 into bit 8
  assign sub_sum = {1'b0, req.a} + {1'b0, ~req.b} + 9'h001;
  assign sub_nib = {1'b0, req.a[3:0]} + {1'b0, ~req.b[3:0]} + 5'h01;

  always_comb begin
    logic_out = req.a;
    res = '0;
    unique case (req.op)
      CSFR_OP_ADD: begin
        res.result = add_sum[7:0];
        res.carry = add_sum[8];
        res.nibble_carry = add_nib[4];
        res.carry_upd = 1'b1;
        res.nibble_carry_upd = 1'b1;
        res.zero_upd = 1'b1;
      end
      CSFR_OP_SUB: begin
        res.result = req.a + neg_b;
        res.carry = sub_sum[8];
        res.nibble_carry = sub_nib[4];
        res.carry_upd = 1'b1;
        res.nibble_carry_upd = 1'b1;
        res.zero_upd = 1'b1;
      end
      CSFR_OP_LOGIC: begin
        res.result = logic_out;
        res.zero_upd = 1'b1;
      end
      CSFR_OP_RL: begin
        res.result = {req.a[6:0], req.b[0]};
        res.carry = req.a[7];
        res.carry_upd = 1'b1;
      end
      CSFR_OP_RR: begin
        res.result = {req.b[0], req.a[7:1]};
        res.carry = req.a[0];
        res.carry_upd = 1'b1;
      end
      CSFR_OP_CLEAR: begin
        res.result = 8'h00;
        res.zero_upd = 1'b1;
      end
      CSFR_OP_MOVE: begin
        res.result = req.a;
      end
      default: begin
        res.result = req.a;
      end
    endcase
    res.zero = (res.result == 8'h00);
  end

endmodule

/* rtl/csfr_core.sv */
// csfr_core: core status flag register with flag update and bank decode
// assumes: decoder supplies op, operands, destination and event pulses
// on sys_clk; rotate b[0] carries the old carry bit in.
`timescale 1ns/10ps
module csfr_core
  import csfr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic master_clear_pin,
  input wire csfr_op_e op,
  input wire logic [7:0] operand_a,
  input wire logic [7:0] operand_b,
  input wire csfr_dst_s dst,
  input wire logic [8:0] rd_addr,
  input wire logic clr_watchdog,
  input wire logic sleep_instr,
  input wire logic watchdog_timeout,
  output logic [7:0] result,
  output logic [7:0] rd_data,
  output logic rd_hit,
  output logic [7:0] status,
  output logic [1:0] direct_bank,
  output logic indirect_bank_select,
  output logic [8:0] direct_addr_base,
  output logic [8:0] indirect_addr_base
);

  csfr_alu_req_s alu_req;
  csfr_alu_res_s alu_res;
  logic master_clear_pin_meta;
  logic master_clear_pin_sync;
  logic [7:0] next_status;
  logic [7:0] wr_mask;
  logic [7:0] wr_value;

  ////////////////////////////////////////////////////////////////////////
  assign alu_req = '{op: op, a: operand_a, b: operand_b};

  csfr_alu u_alu (
    .req(alu_req),
    .res(alu_res)
  );

  ////////////////////////////////////////////////////////////////////////
  // mirrored decode
  wire dst_hit = dst.we && (dst.addr[6:0] == CSFR_STATUS_ADDR[6:0])
                 && (dst.addr[8:7] == 2'b00 || dst.addr == CSFR_STATUS_MIRROR);
  wire rd_sel = (rd_addr == CSFR_STATUS_ADDR) || (rd_addr == CSFR_STATUS_MIRROR);
  // all three flags blocked from the write when op updates any of them
  wire flag_op = alu_res.zero_upd | alu_res.nibble_carry_upd | alu_res.carry_upd;
  assign wr_mask = flag_op ? (CSFR_BANK_MASK) : (CSFR_BANK_MASK | CSFR_FLAG_MASK);
  assign wr_value = alu_res.result;

  // master clear is a pin: two stages before use
  wire master_clear_pin_active = master_clear_pin_sync;

  always_comb begin
    next_status = status;
    if (dst_hit) begin
      next_status = (status & ~wr_mask) | (wr_value & wr_mask);
    end
    if (dst_hit && op == CSFR_OP_CLEAR) begin
      next_status = next_status & ~CSFR_BANK_MASK;
    end
    if (alu_res.zero_upd) begin
      next_status[CSFR_Z_POS] = alu_res.zero;
    end
    if (alu_res.carry_upd) begin
      next_status[CSFR_C_POS] = alu_res.carry;
    end
    if (alu_res.nibble_carry_upd) begin
      next_status[CSFR_DC_POS] = alu_res.nibble_carry;
    end
    if (clr_watchdog) begin
      next_status[CSFR_TO_POS] = 1'b1;
      next_status[CSFR_PD_POS] = 1'b1;
    end
    if (sleep_instr) begin
      next_status[CSFR_TO_POS] = 1'b1;
      next_status[CSFR_PD_POS] = 1'b0;
    end
    // timeout wins: a time-out in the same cycle must not be lost
    if (watchdog_timeout) begin
      next_status[CSFR_TO_POS] = 1'b0;
    end
    if (master_clear_pin_active) begin
      next_status = (status & CSFR_CAUSE_MASK) | next_status & 8'h00;
      next_status[CSFR_TO_POS] = watchdog_timeout ? 1'b0 : status[CSFR_TO_POS];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      master_clear_pin_meta <= 1'b0;
      master_clear_pin_sync <= 1'b0;
    end else begin
      master_clear_pin_meta <= ~master_clear_pin;
      master_clear_pin_sync <= master_clear_pin_meta;
    end
  end

  // rst_n is power-on reset; flags taken as zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= CSFR_POR_VALUE;
    end else begin
      status <= next_status;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      result <= 8'h00;
      rd_data <= 8'h00;
    end else begin
      result <= alu_res.result;
      rd_data <= rd_sel ? next_status : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign rd_hit = rd_sel;
  assign direct_bank = status[CSFR_RP1_POS:CSFR_RP0_POS];
  assign direct_addr_base = {direct_bank, 7'h00};
  assign indirect_bank_select = status[CSFR_IRP_POS];
  assign indirect_addr_base = {indirect_bank_select, 8'h00};

endmodule

/* rtl/csfr_pkg.sv */
// csfr_pkg: constants and carriers for the core status flag register
// assumes: one core clock, decoder/alu on the same clock
package csfr_pkg;

  localparam logic [8:0] CSFR_STATUS_ADDR = 9'h003;
  localparam logic [8:0] CSFR_STATUS_MIRROR = 9'h083;
  localparam logic [6:0] CSFR_LOW_ADDR_MASK = 7'h7f;

  localparam int CSFR_C_POS = 0;
  localparam int CSFR_DC_POS = 1;
  localparam int CSFR_Z_POS = 2;
  localparam int CSFR_PD_POS = 3;
  localparam int CSFR_TO_POS = 4;
  localparam int CSFR_RP0_POS = 5;
  localparam int CSFR_RP1_POS = 6;
  localparam int CSFR_IRP_POS = 7;

  // power-on value 0001 1xxx; unknown flags taken as zero
  localparam logic [7:0] CSFR_POR_VALUE = 8'h18;
  localparam logic [7:0] CSFR_FLAG_MASK = 8'h07;
  localparam logic [7:0] CSFR_CAUSE_MASK = 8'h18;
  localparam logic [7:0] CSFR_BANK_MASK = 8'he0;

  typedef enum logic [7:0] {
    CSFR_OP_NONE = 8'h01,
    CSFR_OP_ADD = 8'h02,
    CSFR_OP_SUB = 8'h04,
    CSFR_OP_LOGIC = 8'h08,
    CSFR_OP_RL = 8'h10,
    CSFR_OP_RR = 8'h20,
    CSFR_OP_CLEAR = 8'h40,
    CSFR_OP_MOVE = 8'h80
  } csfr_op_e;

  typedef struct packed {
    csfr_op_e op;
    logic [7:0] a;
    logic [7:0] b;
  } csfr_alu_req_s;

  typedef struct packed {
    logic [7:0] result;
    logic zero;
    logic nibble_carry;
    logic carry;
    logic zero_upd;
    logic nibble_carry_upd;
    logic carry_upd;
  } csfr_alu_res_s;

  typedef struct packed {
    logic we;
    logic [8:0] addr;
  } csfr_dst_s;

endpackage

/* sim/csfr_props.sv */
// csfr_props: timing and flag relations of the status register
// assumes: bound to csfr_core, single sys_clk domain
`timescale 1ns/10ps
module csfr_props
  import csfr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire csfr_op_e op,
  input wire logic [7:0] operand_a,
  input wire logic [7:0] operand_b,
  input wire csfr_dst_s dst,
  input wire logic [8:0] rd_addr,
  input wire logic clr_watchdog,
  input wire logic sleep_instr,
  input wire logic watchdog_timeout,
  input wire logic rd_hit,
  input wire logic [7:0] status,
  input wire logic [1:0] direct_bank,
  input wire logic indirect_bank_select
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire logic [8:0] sum = {1'h0, operand_a} + operand_b;
  wire logic [4:0] nib = {1'h0, operand_a[3:0]} + operand_b[3:0];
  wire logic evt = clr_watchdog | sleep_instr | watchdog_timeout;
  wire logic to_st = dst.we && (dst.addr == 9'h003 || dst.addr == 9'h083);
  ////////////////////////////////////////
  chk_cause_frozen: assert property (!evt |=> $stable(status[4:3]))
    else $error("cause bits moved");
  chk_timeout_clear: assert property (watchdog_timeout |=> !status[4])
    else $error("timeout not marked");
  chk_sleep_marks: assert property (sleep_instr && !watchdog_timeout |=>
    status[4:3] == 2'h2) else $error("sleep not marked");
  chk_clrwdt_sets: assert property (clr_watchdog && !sleep_instr && !watchdog_timeout |=>
    status[4:3] == 2'h3) else $error("clear watchdog not marked");
  chk_bank_decode: assert property (direct_bank == status[6:5] &&
    indirect_bank_select == status[7]) else $error("bank decode wrong");
  chk_mirror_hit: assert property (rd_hit == (rd_addr == 9'h003 || rd_addr == 9'h083))
    else $error("address hit wrong");
  chk_clear_banks: assert property (op == CSFR_OP_CLEAR && to_st |=>
    status[7:5] == 3'h0 && status[2]) else $error("clear result wrong");
  chk_add_flags: assert property (op == CSFR_OP_ADD |=>
    status[2:0] == {$past(sum[7:0]) == 8'h00, $past(nib[4]), $past(sum[8])})
    else $error("add flags wrong");
  chk_sub_borrow: assert property (op == CSFR_OP_SUB |=>
    status[0] == ($past(operand_a) >= $past(operand_b))) else $error("borrow wrong");
  chk_rotate_left: assert property (op == CSFR_OP_RL |=>
    status[0] == $past(operand_a[7])) else $error("rotate carry wrong");
  chk_flag_block: assert property (op == CSFR_OP_RL && to_st |=>
    status[2:1] == $past(status[2:1])) else $error("flag write not blocked");
  cover property (op == CSFR_OP_CLEAR && to_st);
  cover property (watchdog_timeout);
  cover property (op == CSFR_OP_SUB);
endmodule

bind csfr_core csfr_props u_props (.sys_clk(sys_clk), .rst_n(rst_n), .op(op),
  .operand_a(operand_a), .operand_b(operand_b), .dst(dst), .rd_addr(rd_addr),
  .clr_watchdog(clr_watchdog), .sleep_instr(sleep_instr),
  .watchdog_timeout(watchdog_timeout), .rd_hit(rd_hit), .status(status),
  .direct_bank(direct_bank), .indirect_bank_select(indirect_bank_select));

/* sim/tb_top.sv */
// tb_top: directed tests of the status register at its ports
// assumes: csfr_core alone, checker bound to it
`timescale 1ns/10ps
module tb_top import csfr_pkg::*;;
  logic sys_clk = 1'h0, rst_n = 1'h0, master_clear_pin = 1'h1;
  logic clr_watchdog = 1'h0, sleep_instr = 1'h0, watchdog_timeout = 1'h0;
  csfr_op_e op = CSFR_OP_NONE;
  logic [7:0] operand_a = 8'h00, operand_b = 8'h00, result, rd_data, status;
  csfr_dst_s dst = '0;
  logic [8:0] rd_addr = 9'h000, direct_addr_base, indirect_addr_base;
  logic rd_hit, indirect_bank_select;
  logic [1:0] direct_bank;
  int fails = 0, compares = 0, cycles = 0;
  always #5 sys_clk = ~sys_clk;
  csfr_core DUT (.sys_clk(sys_clk), .rst_n(rst_n), .master_clear_pin(master_clear_pin),
    .op(op), .operand_a(operand_a), .operand_b(operand_b), .dst(dst), .rd_addr(rd_addr),
    .clr_watchdog(clr_watchdog), .sleep_instr(sleep_instr),
    .watchdog_timeout(watchdog_timeout), .result(result), .rd_data(rd_data),
    .rd_hit(rd_hit), .status(status), .direct_bank(direct_bank),
    .indirect_bank_select(indirect_bank_select), .direct_addr_base(direct_addr_base),
    .indirect_addr_base(indirect_addr_base));
  ////////////////////////////////////////
  task automatic chk(string n, logic [8:0] s, logic [8:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // one op per call, held one cycle, then back to idle; status settles 1 ns after the capturing edge
  task automatic run(csfr_op_e o, logic [7:0] a, logic [7:0] b, logic [9:0] d);
    @(posedge sys_clk);
    op <= o;
    operand_a <= a;
    operand_b <= b;
    dst <= d;
    @(posedge sys_clk);
    op <= CSFR_OP_NONE;
    dst <= '0;
    #1;
  endtask
  task automatic evt(logic [2:0] e);
    @(posedge sys_clk);
    {clr_watchdog, sleep_instr, watchdog_timeout} <= e;
    @(posedge sys_clk);
    {clr_watchdog, sleep_instr, watchdog_timeout} <= 3'h0;
    #1;
  endtask
  task automatic rd(logic [8:0] a, logic [8:0] e);
    @(posedge sys_clk);
    rd_addr <= a;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("rd_data", rd_data, e);
  endtask
  task automatic print_verdict();
    if (fails == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // hang guard; the tests need well under a hundred cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      print_verdict();
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'h1;
    #1;
    chk("por", status, 9'h018);
    rd(9'h003, 9'h018);
    rd(9'h004, 9'h000);
    run(CSFR_OP_ADD, 8'h0f, 8'h01, 10'h203);
    chk("add_dst", status, 9'h01a);
    chk("add_res", result, 9'h010);
    for (int i = 0; i < 4; i++) begin
      run(CSFR_OP_MOVE, 8'(i * 32), 8'(i * 32), 10'h203);
      chk("dbase", direct_addr_base, 9'(i * 128));
      chk("ibase", indirect_addr_base, 9'h000);
    end
    run(CSFR_OP_MOVE, 8'hff, 8'hff, 10'h283);
    chk("mirror", status, 9'h0ff);
    chk("ibase", indirect_addr_base, 9'h100);
    rd(9'h083, 9'h0ff);
    run(CSFR_OP_CLEAR, 8'h00, 8'h00, 10'h203);
    chk("clear", status, 9'h01f);
    run(CSFR_OP_ADD, 8'h80, 8'h80, 10'h000);
    chk("add_zero", status, 9'h01d);
    run(CSFR_OP_SUB, 8'h05, 8'h06, 10'h000);
    chk("sub_borrow", status, 9'h018);
    chk("sub_res", result, 9'h0ff);
    run(CSFR_OP_SUB, 8'h16, 8'h06, 10'h000);
    chk("sub_ok", status, 9'h01b);
    run(CSFR_OP_RL, 8'h80, 8'h00, 10'h000);
    chk("rl", status[0], 9'h001);
    run(CSFR_OP_RR, 8'h02, 8'h01, 10'h000);
    chk("rr", status[0], 9'h000);
    // rotate into status: result bits 2:1 must not land
    run(CSFR_OP_RL, 8'h02, 8'h00, 10'h203);
    chk("rl_dst", status, 9'h01a);
    run(CSFR_OP_LOGIC, 8'h00, 8'h00, 10'h000);
    chk("logic_zero", status, 9'h01e);
    evt(3'h2);
    chk("sleep", status[4:3], 9'h002);
    evt(3'h1);
    chk("timeout", status[4:3], 9'h000);
    // cause bits are zero here, so a write of ones would show
    run(CSFR_OP_MOVE, 8'h1f, 8'h1f, 10'h203);
    chk("cause_ro", status, 9'h007);
    evt(3'h4);
    chk("clrwdt", status[4:3], 9'h003);
    evt(3'h2);
    @(posedge sys_clk);
    master_clear_pin <= 1'h0;
    repeat (4) @(posedge sys_clk);
    master_clear_pin <= 1'h1;
    repeat (4) @(posedge sys_clk);
    #1;
    chk("master_clear_pin", status, 9'h010);
    print_verdict();
  end
endmodule
